/* File: dma_ahb_slave_model.sv */
/*
  Bus slave model: 64-word memory with optional wait states and an
  error answer at one fixed address.
  Assumes a single master that holds its request until accepted.
*/
`timescale 1ns/100ps
`default_nettype none

module dma_ahb_slave_model (
  // Clock and bus
  input  wire logic              i_clk_sys,
  input  wire dma_pkg::ahb_req_t i_ahb,
  // Pace: wait states per data phase
  input  wire logic [1:0]        i_waits,
  // Slave answer
  output logic [31:0]            o_hrdata,
  output logic                   o_hready,
  output logic                   o_hresp
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam logic [31:0] ERR_ADDR = 32'h000000fc;  // Error target
  logic [31:0] mem [64];
  logic        ph   = 1'b0;   // Data phase open
  logic        wr   = 1'b0;
  logic        err  = 1'b0;
  logic [5:0]  idx  = '0;
  logic [1:0]  w    = '0;
  logic [7:0]  junk = '0;     // Moving pattern off the data phase
  initial for (int i = 0; i < 64; i++) mem[i] = 32'ha5000000 | i;
  assign o_hready = !ph || (w == 2'h0);
  assign o_hresp  = ph && err && (w == 2'h0);
  // Read data only valid at the end of a read data phase
  assign o_hrdata = (ph && !wr && w == 2'h0) ? mem[idx] : {4{junk}};
  // Accept and finish transfers; any address is a target
  always @(posedge i_clk_sys) begin
    junk <= junk + 8'h1;
    if (ph) begin
      if (w != 2'h0) w <= w - 2'h1;
      else begin
        ph <= 1'b0;
        if (wr && !err) mem[idx] <= i_ahb.hwdata;
      end
    end
    if (o_hready && i_ahb.htrans == dma_pkg::HTRANS_NONSEQ) begin
      ph  <= 1'b1;
      wr  <= i_ahb.hwrite;
      idx <= i_ahb.haddr[7:2];
      err <= (i_ahb.haddr == ERR_ADDR);
      w   <= i_waits;
    end
  end
endmodule

`default_nettype wire

/* File: dma_controller.sv */
/*
  Seven-channel DMA engine with one AHB-Lite style master port and the
  request multiplexer in front. Configuration and status are plain ports.
  Assumes AHB slaves answer with hready/hresp and that software keeps a
  channel's configuration still while it is active.
*/
`timescale 1ns/100ps
`default_nettype none

module dma_controller (
  // Clock and reset
  input  wire logic                                      i_clk_sys,
  input  wire logic                                      i_rst_n,
  // Channel control
  input  wire dma_pkg::ch_cfg_t  [dma_pkg::NUM_CH-1:0]   i_ch_cfg,
  input  wire logic [dma_pkg::NUM_CH-1:0]                i_ch_start,
  input  wire logic [dma_pkg::NUM_CH-1:0]                i_ch_stop,
  input  wire logic [dma_pkg::NUM_CH-1:0]                i_flag_clr,
  input  wire dma_pkg::ch_flags_t [dma_pkg::NUM_CH-1:0]  i_irq_en,
  // Multiplexer control and request sources
  input  wire dma_pkg::mux_cfg_t [dma_pkg::NUM_CH-1:0]   i_mux_cfg,
  input  wire dma_pkg::gen_cfg_t [dma_pkg::NUM_GEN-1:0]  i_gen_cfg,
  input  wire logic [dma_pkg::NUM_PREQ-1:0]              i_preq,
  input  wire logic [dma_pkg::NUM_SYNC-1:0]              i_sync,
  // Channel status
  output var  dma_pkg::ch_flags_t [dma_pkg::NUM_CH-1:0]  o_flags,
  output var  logic [dma_pkg::NUM_CH-1:0]                o_active,
  output var  logic [dma_pkg::NUM_CH-1:0]                o_irq,
  output var  logic [dma_pkg::NUM_CH-1:0]                o_req_ack,
  // Bus master
  output var  dma_pkg::ahb_req_t                         o_ahb,
  input  wire logic [31:0]                               i_hrdata,
  input  wire logic                                      i_hready,
  input  wire logic                                      i_hresp
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_RADDR, ST_RDATA, ST_WADDR, ST_WDATA
  } state_t;

  state_t                          state_q, state_d;
  logic [dma_pkg::CH_W-1:0]        ch_q, ch_d;       // Channel in service
  dma_pkg::ahb_req_t               ahb_q, ahb_d;     // Bus outputs
  logic [31:0]                     data_q, data_d;   // Item in flight
  logic [dma_pkg::NUM_CH-1:0]      ack_q, ack_d;
  logic                            done_ok, done_err;
  logic [31:0]                     rd_val, wr_val;

  // Per-channel state
  logic [dma_pkg::NUM_CH-1:0]      act_q, act_d;
  logic [dma_pkg::CNT_W-1:0]       cnt_q [dma_pkg::NUM_CH];
  logic [dma_pkg::CNT_W-1:0]       cnt_d [dma_pkg::NUM_CH];
  logic [31:0]                     sa_q  [dma_pkg::NUM_CH];
  logic [31:0]                     sa_d  [dma_pkg::NUM_CH];
  logic [31:0]                     da_q  [dma_pkg::NUM_CH];
  logic [31:0]                     da_d  [dma_pkg::NUM_CH];
  dma_pkg::ch_flags_t              flg_q [dma_pkg::NUM_CH];
  dma_pkg::ch_flags_t              flg_d [dma_pkg::NUM_CH];
  logic [dma_pkg::NUM_CH-1:0]      irq_q, irq_d;

  // Arbitration
  logic [dma_pkg::NUM_CH-1:0]      ch_req;   // Routed requests
  logic [dma_pkg::NUM_CH-1:0]      pend;
  logic                            gnt_v;
  logic [dma_pkg::CH_W-1:0]        gnt_ch;
  dma_pkg::prio_t                  best;

  // ----------------------------------------------------------------
  // Request multiplexer
  // ----------------------------------------------------------------
  dma_request_mux u_mux (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_preq    (i_preq),
    .i_sync    (i_sync),
    .i_mux_cfg (i_mux_cfg),
    .i_gen_cfg (i_gen_cfg),
    .i_ack     (ack_q),
    .o_ch_req  (ch_req)
  );

  // ----------------------------------------------------------------
  // Arbiter
  // ----------------------------------------------------------------
  // Pending: active and either software triggered or requested.
  // The ack cycle is masked so a level request is not served twice.
  always_comb begin
    for (int i = 0; i < dma_pkg::NUM_CH; i++) begin
      pend[i] = act_q[i] & ~ack_q[i] &
                (i_ch_cfg[i].mem2mem | ch_req[i]);
    end
  end

  // Strictly greater priority replaces, so ties keep the lower index
  always_comb begin
    gnt_v  = 1'b0;
    gnt_ch = '0;
    best   = dma_pkg::PRIO_LOW;
    for (int i = 0; i < dma_pkg::NUM_CH; i++) begin
      if (pend[i] && (!gnt_v || i_ch_cfg[i].prio > best)) begin
        gnt_v  = 1'b1;
        gnt_ch = dma_pkg::CH_W'(i);
        best   = i_ch_cfg[i].prio;
      end
    end
  end

  // ----------------------------------------------------------------
  // Data lanes
  // ----------------------------------------------------------------
  // Read lane picked by address, then packed/unpacked to the
  // destination width by truncation or zero extension.
  always_comb begin
    rd_val = i_hrdata >> {ahb_q.haddr[1:0], 3'h0};
    unique case (i_ch_cfg[ch_q].src_size)
      dma_pkg::SZ_BYTE: rd_val = {24'h0, rd_val[7:0]};
      dma_pkg::SZ_HALF: rd_val = {16'h0, rd_val[15:0]};
      default:          rd_val = rd_val;
    endcase
    unique case (i_ch_cfg[ch_q].dst_size)
      dma_pkg::SZ_BYTE: wr_val = {4{data_q[7:0]}};
      dma_pkg::SZ_HALF: wr_val = {2{data_q[15:0]}};
      default:          wr_val = data_q;
    endcase
  end

  // ----------------------------------------------------------------
  // Bus engine
  // ----------------------------------------------------------------
  // One read then one write per item; single transfers only, which
  // costs throughput; a stop acts between items, not between an item's read and write.
  always_comb begin
    state_d  = state_q;
    ch_d     = ch_q;
    ahb_d    = ahb_q;
    data_d   = data_q;
    ack_d    = '0;
    done_ok  = 1'b0;
    done_err = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        // Issue the read address of the granted channel
        if (gnt_v) begin
          ch_d         = gnt_ch;
          ahb_d.haddr  = sa_q[gnt_ch];
          ahb_d.htrans = dma_pkg::HTRANS_NONSEQ;
          ahb_d.hwrite = 1'b0;
          ahb_d.hsize  = {1'b0, i_ch_cfg[gnt_ch].src_size};
          state_d      = ST_RADDR;
        end
      end
      ST_RADDR: begin
        if (i_hready) begin
          ahb_d.htrans = dma_pkg::HTRANS_IDLE;
          state_d      = ST_RDATA;
        end
      end
      ST_RDATA: begin
        if (i_hready && i_hresp) begin
          done_err = 1'b1;
          state_d  = ST_IDLE;
        end else if (i_hready) begin
          data_d       = rd_val;
          ahb_d.haddr  = da_q[ch_q];
          ahb_d.htrans = dma_pkg::HTRANS_NONSEQ;
          ahb_d.hwrite = 1'b1;
          ahb_d.hsize  = {1'b0, i_ch_cfg[ch_q].dst_size};
          state_d      = ST_WADDR;
        end
      end
      ST_WADDR: begin
        if (i_hready) begin
          ahb_d.htrans = dma_pkg::HTRANS_IDLE;
          ahb_d.hwdata = wr_val;
          state_d      = ST_WDATA;
        end
      end
      ST_WDATA: begin
        if (i_hready) begin
          done_err     = i_hresp;
          done_ok      = ~i_hresp;
          ack_d[ch_q]  = ~i_hresp;
          ahb_d.hwrite = 1'b0;
          state_d      = ST_IDLE;
        end
      end
    endcase
  end

  // Engine registers
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      state_q <= ST_IDLE;
      ch_q    <= '0;
      ahb_q   <= '0;
      data_q  <= '0;
      ack_q   <= '0;
    end else begin
      state_q <= state_d;
      ch_q    <= ch_d;
      ahb_q   <= ahb_d;
      data_q  <= data_d;
      ack_q   <= ack_d;
    end
  end

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  for (genvar g = 0; g < dma_pkg::NUM_CH; g++) begin : g_ch
    dma_pkg::ch_cfg_t          cfg;
    dma_pkg::ch_flags_t        set;     // Events this cycle
    logic                      hit_ok, hit_err;
    logic [dma_pkg::CNT_W-1:0] cnt_n;

    assign cfg = i_ch_cfg[g];

    // Next channel state: start, item done, error, stop, flags
    always_comb begin
      act_d[g] = act_q[g];
      cnt_d[g] = cnt_q[g];
      sa_d[g]  = sa_q[g];
      da_d[g]  = da_q[g];
      set      = '0;
      hit_ok   = done_ok  && ch_q == dma_pkg::CH_W'(g) && act_q[g];
      hit_err  = done_err && ch_q == dma_pkg::CH_W'(g) && act_q[g];
      cnt_n    = cnt_q[g] - 16'h1;
      if (i_ch_start[g]) begin
        // A zero count leaves the channel idle
        act_d[g] = cfg.count != '0;
        cnt_d[g] = cfg.count;
        sa_d[g]  = cfg.src_addr;
        da_d[g]  = cfg.dst_addr;
      end else if (hit_err) begin
        set.te   = 1'b1;
        act_d[g] = 1'b0;
      end else if (hit_ok) begin
        cnt_d[g] = cnt_n;
        if (cfg.src_inc) begin
          sa_d[g] = sa_q[g] + (32'h1 << cfg.src_size);
        end
        if (cfg.dst_inc) begin
          da_d[g] = da_q[g] + (32'h1 << cfg.dst_size);
        end
        if (cnt_n == (cfg.count >> 1)) begin
          set.ht = 1'b1;
        end
        if (cnt_n == '0) begin
          set.tc = 1'b1;
          if (cfg.circular && !cfg.mem2mem) begin
            // Buffer restarts from its programmed start
            cnt_d[g] = cfg.count;
            sa_d[g]  = cfg.src_addr;
            da_d[g]  = cfg.dst_addr;
          end else begin
            act_d[g] = 1'b0;
          end
        end
      end
      if (i_ch_stop[g]) begin
        act_d[g] = 1'b0;
      end
      // A new event wins over a clear in the same cycle
      flg_d[g] = (flg_q[g] & ~{3{i_flag_clr[g]}}) | set;
      irq_d[g] = |(flg_d[g] & i_irq_en[g]);
    end

    // Channel registers
    always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
        act_q[g] <= 1'b0;
        cnt_q[g] <= '0;
        sa_q[g]  <= '0;
        da_q[g]  <= '0;
        flg_q[g] <= '0;
        irq_q[g] <= 1'b0;
      end else begin
        act_q[g] <= act_d[g];
        cnt_q[g] <= cnt_d[g];
        sa_q[g]  <= sa_d[g];
        da_q[g]  <= da_d[g];
        flg_q[g] <= flg_d[g];
        irq_q[g] <= irq_d[g];
      end
    end

    assign o_flags[g] = flg_q[g];
  end

  // Outputs
  assign o_active  = act_q;
  assign o_irq     = irq_q;
  assign o_req_ack = ack_q;
  assign o_ahb     = ahb_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic viol_hi, viol_tie;  // Helper for arbitration checks

  always_comb begin
    viol_hi  = 1'b0;
    viol_tie = 1'b0;
    for (int i = 0; i < dma_pkg::NUM_CH; i++) begin
      if (pend[i] && i_ch_cfg[i].prio > i_ch_cfg[gnt_ch].prio) begin
        viol_hi = 1'b1;
      end
      if (pend[i] && i_ch_cfg[i].prio == i_ch_cfg[gnt_ch].prio &&
          dma_pkg::CH_W'(i) < gnt_ch) begin
        viol_tie = 1'b1;
      end
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  // Only an item of a live channel with no restart in the same cycle counts
  sequence s_bus_err;
    (state_q == ST_RDATA || state_q == ST_WDATA) && i_hready && i_hresp &&
    act_q[ch_q] && !i_ch_start[ch_q];
  endsequence

  sequence s_item_ok;
    state_q == ST_WDATA && i_hready && !i_hresp && act_q[ch_q] && !i_ch_start[ch_q];
  endsequence

  addr_hold_a: assert property (
    o_ahb.htrans == dma_pkg::HTRANS_NONSEQ && !i_hready
    |=> $stable(o_ahb.haddr) && o_ahb.htrans == dma_pkg::HTRANS_NONSEQ)
    else $error("Address phase dropped before ready");

  rd_size_a: assert property (
    state_q == ST_RADDR |-> !o_ahb.hwrite &&
    o_ahb.hsize == {1'b0, i_ch_cfg[ch_q].src_size})
    else $error("Read issued with wrong size");

  prio_win_a: assert property (gnt_v |-> !viol_hi)
    else $error("Lower priority channel granted");

  tie_low_a: assert property (gnt_v |-> !viol_tie)
    else $error("Equal priority tie not given to lower channel");

  grant_go_a: assert property (
    state_q == ST_IDLE && |pend |=> state_q == ST_RADDR ##1 o_ahb.htrans == dma_pkg::HTRANS_NONSEQ || state_q == ST_RDATA)
    else $error("Pending channel not served");

  err_stop_a: assert property (
    s_bus_err |=> flg_q[$past(ch_q)].te && !act_q[$past(ch_q)])
    else $error("Bus error did not stop channel");

  cnt_dec_a: assert property (
    s_item_ok and (cnt_q[ch_q] > 16'h1) |=>
    cnt_q[$past(ch_q)] == 16'($past(cnt_q[ch_q]) - 16'h1))
    else $error("Item count not decremented");

  tc_irq_a: assert property (
    s_item_ok and (cnt_q[ch_q] == 16'h1 && i_irq_en[ch_q].tc) |=>
    flg_q[$past(ch_q)].tc && o_irq[$past(ch_q)])
    else $error("Transfer complete not raised");

  half_flag_a: assert property (
    s_item_ok and (16'(cnt_q[ch_q] - 16'h1) == (i_ch_cfg[ch_q].count >> 1))
    |=> flg_q[$past(ch_q)].ht)
    else $error("Half transfer not flagged");

endmodule

`default_nettype wire

/* File: dma_controller_request_mux_tb_top.sv */
/*
  Self-checking bench for the DMA engine, one task per scenario.
  Assumes the slave model above and a 20 MHz system clock.
*/
`timescale 1ns/100ps
`default_nettype none

module dma_controller_request_mux_tb_top;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  dma_pkg::ch_cfg_t [6:0] cfg;
  dma_pkg::mux_cfg_t [6:0] mux;
  dma_pkg::gen_cfg_t [3:0] gen;
  dma_pkg::ch_flags_t [6:0] irq_en, flags;
  logic [6:0] start, stop, clr, active, irq, ack;
  logic [19:0] preq;
  logic [7:0] sync;
  logic [1:0] waits;
  dma_pkg::ahb_req_t ahb;
  logic [31:0] hrdata;
  logic hready, hresp;
  int err_count = 0;
  int compares = 0;
  int cyc = 0;

  dma_controller i_dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_ch_cfg(cfg),
    .i_ch_start(start), .i_ch_stop(stop), .i_flag_clr(clr), .i_irq_en(irq_en),
    .i_mux_cfg(mux), .i_gen_cfg(gen), .i_preq(preq), .i_sync(sync), .o_flags(flags),
    .o_active(active), .o_irq(irq), .o_req_ack(ack), .o_ahb(ahb), .i_hrdata(hrdata),
    .i_hready(hready), .i_hresp(hresp));
  dma_ahb_slave_model u_mem (.i_clk_sys(i_clk_sys), .i_ahb(ahb), .i_waits(waits),
    .o_hrdata(hrdata), .o_hready(hready), .o_hresp(hresp));

  // ----------------------------------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------------------------------
  initial forever #25 i_clk_sys = ~i_clk_sys;
  // A hang counts as a mismatch
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      results();
    end
  end
  task automatic tick;
    @(posedge i_clk_sys);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Channel setup, both addresses incrementing
  task automatic set(input int c, input logic [31:0] s, d, input logic [15:0] n,
      input dma_pkg::size_t ss, ds, input logic circ, m2m, input dma_pkg::prio_t p,
      input logic [4:0] sel);
    cfg[c] = '{s, d, n, ss, ds, 1'b1, 1'b1, circ, m2m, p};
    mux[c] = '{sel, 1'b0, 3'h0};
  endtask
  task automatic go(input logic [6:0] m);
    start = m;
    tick;
    start = '0;
    tick;
  endtask
  // Waits for the next acknowledge of one channel, bounded
  task automatic wait_ack(input int c);
    for (int k = 0; k < 80; k++) begin
      tick;
      if (ack[c]) break;
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_copy;
    set(0, 32'h10, 32'h80, 16'h4, dma_pkg::SZ_WORD, dma_pkg::SZ_WORD, 1'b0, 1'b1,
        dma_pkg::PRIO_LOW, 5'h1f);
    irq_en[0] = 3'b111;
    go(7'h01);
    for (int i = 0; i < 4; i++) begin
      wait_ack(0);
      chk("ack0", ack[0], 1'b1);
      if (i == 1) chk("half", flags[0], 3'b010);
    end
    tick;
    chk("done", active[0], 1'b0);
    chk("flags0", flags[0], 3'b110);
    chk("irq0", irq[0], 1'b1);
    for (int i = 0; i < 4; i++) chk("copy", u_mem.mem[32+i], 32'ha5000004 | i);
    clr = 7'h01;
    tick;
    clr = '0;
    tick;
    chk("clear", irq[0], 1'b0);
  endtask
  task automatic t_count;
    set(1, 32'h40, 32'h40, 16'h0, dma_pkg::SZ_WORD, dma_pkg::SZ_WORD, 1'b0, 1'b1,
        dma_pkg::PRIO_LOW, 5'h1f);
    go(7'h02);
    chk("zero", active[1], 1'b0);
    cfg[1].count = 16'hffff;
    go(7'h02);
    chk("max", active[1], 1'b1);
    stop = 7'h02;
    tick;
    stop = '0;
    repeat (8) tick;
    chk("stopped", active[1], 1'b0);
  endtask
  // Two channels start together; the first acknowledge shows the winner
  task automatic t_race(input int a, b, input dma_pkg::prio_t pa, pb, input int w);
    set(a, 32'h20, 32'h20, 16'h1, dma_pkg::SZ_WORD, dma_pkg::SZ_WORD, 1'b0, 1'b1, pa, 5'h1f);
    set(b, 32'h20, 32'h20, 16'h1, dma_pkg::SZ_WORD, dma_pkg::SZ_WORD, 1'b0, 1'b1, pb, 5'h1f);
    go(7'(1 << a) | 7'(1 << b));
    for (int k = 0; k < 80 && ack == '0; k++) tick;
    chk("winner", ack, 7'(1 << w));
    repeat (20) tick;
  endtask
  task automatic t_periph;
    int n = 0;
    set(6, 32'h24, 32'h24, 16'h2, dma_pkg::SZ_WORD, dma_pkg::SZ_WORD, 1'b1, 1'b0,
        dma_pkg::PRIO_LOW, 5'h3);
    waits = 2'h2;
    go(7'h40);
    for (int k = 0; k < 10; k++) begin
      tick;
      if (ahb.htrans !== dma_pkg::HTRANS_IDLE) n++;
    end
    chk("noreq", n, 0);
    for (int i = 0; i < 3; i++) begin
      preq[3] = 1'b1;
      wait_ack(6);
      chk("ack6", ack[6], 1'b1);
      preq[3] = 1'b0;
      tick;
    end
    chk("circ", {flags[6].tc, active[6]}, 2'b11);
    stop = 7'h40;
    tick;
    stop = '0;
    waits = 2'h0;
    repeat (8) tick;
  endtask
  task automatic t_err;
    set(0, 32'hfc, 32'h80, 16'h3, dma_pkg::SZ_WORD, dma_pkg::SZ_WORD, 1'b0, 1'b1,
        dma_pkg::PRIO_LOW, 5'h1f);
    go(7'h01);
    for (int k = 0; k < 40 && active[0]; k++) tick;
    chk("error", {flags[0], active[0]}, 4'b0010);
  endtask
  task automatic t_pack;
    set(1, 32'h7, 32'hc0, 16'h1, dma_pkg::SZ_BYTE, dma_pkg::SZ_WORD, 1'b0, 1'b1,
        dma_pkg::PRIO_LOW, 5'h1f);
    go(7'h02);
    wait_ack(1);
    chk("pack", u_mem.mem[48], 32'h000000a5);
  endtask
  task automatic t_gen;
    gen[0] = '{1'b1, 3'h2};
    set(2, 32'h28, 32'h28, 16'h1, dma_pkg::SZ_WORD, dma_pkg::SZ_WORD, 1'b0, 1'b0,
        dma_pkg::PRIO_LOW, 5'd20);
    // Channel 3 takes peripheral line 3, gated by the same sync input
    set(3, 32'h2c, 32'h2c, 16'h1, dma_pkg::SZ_WORD, dma_pkg::SZ_WORD, 1'b0, 1'b0,
        dma_pkg::PRIO_LOW, 5'h3);
    mux[3].sync_en = 1'b1;
    mux[3].sync_sel = 3'h2;
    preq[3] = 1'b1;
    go(7'h0c);
    repeat (8) tick;
    chk("gated", active[3], 1'b1);
    chk("genwait", active[2], 1'b1);
    sync[2] = 1'b1;
    tick;
    sync = '0;
    wait_ack(2);
    chk("gen", ack[2], 1'b1);
    wait_ack(3);
    chk("sync", ack[3], 1'b1);
    preq[3] = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    cfg = '0;
    gen = '0;
    irq_en = '0;
    {start, stop, clr, preq, sync, waits} = '0;
    foreach (mux[c]) mux[c] = '{5'h1f, 1'b0, 3'h0};
    repeat (6) tick;
    i_rst_n = 1'b1;
    tick;
    t_copy;
    t_count;
    t_race(2, 3, dma_pkg::PRIO_LOW, dma_pkg::PRIO_HIGH, 3);
    t_race(4, 5, dma_pkg::PRIO_MED, dma_pkg::PRIO_MED, 4);
    t_race(5, 6, dma_pkg::PRIO_VHIGH, dma_pkg::PRIO_HIGH, 5);
    t_periph;
    t_err;
    t_pack;
    t_gen;
    results();
  end
endmodule

`default_nettype wire

/* File: dma_pkg.sv */
/*
  Shared constants and carrier types for the seven-channel DMA engine
  and its request multiplexer.
  Assumes one system clock and a synchronous active-low reset.
*/
`default_nettype none

package dma_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_CH    = 7;   // Channels
  localparam int NUM_PREQ  = 20;  // Peripheral request lines
  localparam int NUM_GEN   = 4;   // Request generators
  localparam int NUM_LINES = NUM_PREQ + NUM_GEN;
  localparam int NUM_SYNC  = 8;   // Sync and trigger inputs
  localparam int SEL_W     = 5;
  localparam int SYNC_W    = 3;
  localparam int CH_W      = 3;
  localparam int CNT_W     = 16;  // Item counter width

  // ----------------------------------------------------------------
  // Bus encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] HTRANS_IDLE   = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Encoded as the bus size field: byte, half-word, word
  typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD} size_t;
  typedef enum logic [1:0] {PRIO_LOW, PRIO_MED, PRIO_HIGH, PRIO_VHIGH} prio_t;

  typedef struct packed {
    logic [31:0]      src_addr;
    logic [31:0]      dst_addr;
    logic [CNT_W-1:0] count;
    size_t            src_size;
    size_t            dst_size;
    logic             src_inc;
    logic             dst_inc;
    logic             circular;
    logic             mem2mem;   // Software trigger, no request
    prio_t            prio;
  } ch_cfg_t;

  typedef struct packed {
    logic [SEL_W-1:0]  req_sel;
    logic              sync_en;
    logic [SYNC_W-1:0] sync_sel;
  } mux_cfg_t;

  typedef struct packed {
    logic              en;
    logic [SYNC_W-1:0] trig_sel;
  } gen_cfg_t;

  typedef struct packed {
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
  } ahb_req_t;

  typedef struct packed {
    logic tc;
    logic ht;
    logic te;
  } ch_flags_t;
endpackage

`default_nettype wire

/* File: dma_request_mux.sv */
/*
  Request multiplexer: routes one request line to each channel, with
  optional sync gating, and runs the request generators.
  Assumes inputs synchronous to i_clk_sys; a peripheral drops its
  request in the cycle its acknowledge is high.
*/
`timescale 1ns/100ps
`default_nettype none

module dma_request_mux (
  // Clock and reset
  input  wire logic                                      i_clk_sys,
  input  wire logic                                      i_rst_n,
  // Request sources
  input  wire logic [dma_pkg::NUM_PREQ-1:0]              i_preq,
  input  wire logic [dma_pkg::NUM_SYNC-1:0]              i_sync,
  // Configuration
  input  wire dma_pkg::mux_cfg_t [dma_pkg::NUM_CH-1:0]   i_mux_cfg,
  input  wire dma_pkg::gen_cfg_t [dma_pkg::NUM_GEN-1:0]  i_gen_cfg,
  // Channel side
  input  wire logic [dma_pkg::NUM_CH-1:0]                i_ack,
  output var  logic [dma_pkg::NUM_CH-1:0]                o_ch_req
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [dma_pkg::NUM_SYNC-1:0]  sync_prev_q;  // Edge reference
  logic [dma_pkg::NUM_SYNC-1:0]  sync_rise;
  logic [dma_pkg::NUM_CH-1:0]    armed_q, armed_d;
  logic [dma_pkg::NUM_GEN-1:0]   gen_q, gen_d;
  logic [dma_pkg::NUM_LINES-1:0] lines;

  assign sync_rise = i_sync & ~sync_prev_q;
  assign lines     = {gen_q, i_preq};

  // Next values: arm flags, generator requests, routed requests
  always_comb begin
    armed_d = armed_q;
    gen_d   = gen_q;
    for (int c = 0; c < dma_pkg::NUM_CH; c++) begin
      // Sync edge arms the gate; a new edge wins over the ack
      if (i_ack[c]) begin
        armed_d[c] = 1'b0;
      end
      if (i_mux_cfg[c].sync_en && sync_rise[i_mux_cfg[c].sync_sel]) begin
        armed_d[c] = 1'b1;
      end
      // Out-of-range selections route nothing
      o_ch_req[c] = 1'b0;
      if (int'(i_mux_cfg[c].req_sel) < dma_pkg::NUM_LINES) begin
        o_ch_req[c] = lines[i_mux_cfg[c].req_sel] &
                      (~i_mux_cfg[c].sync_en | armed_q[c]);
      end
    end
    for (int g = 0; g < dma_pkg::NUM_GEN; g++) begin
      // A served generator request is retired by its channel's ack
      for (int c = 0; c < dma_pkg::NUM_CH; c++) begin
        if (i_ack[c] && int'(i_mux_cfg[c].req_sel) == dma_pkg::NUM_PREQ + g) begin
          gen_d[g] = 1'b0;
        end
      end
      if (i_gen_cfg[g].en && sync_rise[i_gen_cfg[g].trig_sel]) begin
        gen_d[g] = 1'b1;
      end
    end
  end

  // Registers
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      sync_prev_q <= '0;
      armed_q     <= '0;
      gen_q       <= '0;
    end else begin
      sync_prev_q <= i_sync;
      armed_q     <= armed_d;
      gen_q       <= gen_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  for (genvar g = 0; g < dma_pkg::NUM_GEN; g++) begin : g_chk
    gen_fire_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      i_gen_cfg[g].en && sync_rise[i_gen_cfg[g].trig_sel] |=> gen_q[g])
      else $error("Generator missed its trigger edge");
  end

endmodule

`default_nettype wire
